/* vcd_cfg.svh */
// Purpose: constants for the volatile configuration download block
// Assumes: 8-bit register space reached over the two-wire serial bus
// Notes:   offsets, field positions and reset values live here as macros
`ifndef VCD_CFG_SVH
`define VCD_CFG_SVH

// bus slave address, fixed by the device
`define VCD_I2C_ADDR        7'h6a

// mode register and its values
`define VCD_MODE_ADDR       8'h06
`define VCD_MODE_READY      8'h01
`define VCD_MODE_ACTIVE     8'h02
`define VCD_MODE_RESET      8'h00

// clock plan register layout
`define VCD_INT_DIV_BASE    8'h20
`define VCD_INT_DIV_COUNT   5
`define VCD_FRAC_DIV_BASE   8'h28
`define VCD_FRAC_DIV_COUNT  2
`define VCD_INPUT_MUX_ADDR  8'h2c
`define VCD_FB_INT_LO       8'h30
`define VCD_FB_INT_HI       8'h31
`define VCD_FB_NUM_LO       8'h32
`define VCD_FB_NUM_HI       8'h33
`define VCD_FB_DEN_LO       8'h34
`define VCD_FB_DEN_HI       8'h35

// pin function area, never writable from the bus
`define VCD_GPI_BASE        8'hf0

// i2c frame bit count
`define VCD_BITS_PER_BYTE   4'h8

`endif

/* vcd_pkg.sv */
// Purpose: types shared by the volatile configuration download block
// Assumes: constants come from vcd_cfg.svh
// Notes:   nothing here is imported; users write vcd_pkg::name
package vcd_pkg;

    // source feeding the pll
    typedef enum logic [1:0] {
        SRC_XTAL,
        SRC_CLKIN1,
        SRC_CLKIN2,
        SRC_DIFF
    } input_source_type;

    // serial slave states
    typedef enum logic [3:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_PTR,
        ST_PTR_ACK,
        ST_DATA,
        ST_DATA_ACK,
        ST_READ,
        ST_READ_ACK
    } i2c_state_type;

    // clock plan handed to the synthesis core on activation
    typedef struct packed {
        logic [4:0][7:0]  int_div;
        logic [1:0][7:0]  frac_div;
        logic [14:0]      fb_integer;
        logic [14:0]      fb_numerator;
        logic [14:0]      fb_denominator;
        input_source_type input_sel;
    } clock_plan_type;

endpackage

/* vcd_sync.sv */
// Purpose: two flip-flop synchroniser for a bank of asynchronous pins
// Assumes: each bit is an independent level
// Notes:   the first stage is read only by the second stage
`timescale 1ns/10ps
module vcd_sync #(
    parameter int W = 1
) (
    input  wire logic         i_core_clk,
    input  wire logic         i_rst_n,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);

    logic [W-1:0] stage1;
    logic [W-1:0] next_stage1;
    logic [W-1:0] next_sync;

    // next values of both stages
    always_comb begin
        next_stage1 = i_async;
        next_sync   = stage1;
    end

    // register both stages
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            stage1 <= '0;
            o_sync <= '0;
        end else begin
            stage1 <= next_stage1;
            o_sync <= next_sync;
        end
    end

endmodule

/* volatile_config_download.sv */
// Purpose: serial download of a single-profile volatile configuration into a blank clock generator
// Assumes: host is the serial bus master; power-up reset only
// Notes:   clocks start once ready mode then active mode have been written
//
// Contract
// (RL1) blank device or profile drives no clocks until a configuration is downloaded
// (RL2) pin functions cannot be written over the bus; blank device pins do nothing
// (RL3) globally assigned pins keep working in a blank profile; none can be added
// (RL4) host downloads single-profile configurations only
// (RL5) host keeps the bus slave address unchanged
// (RL6) host writes every address/data pair in list order, none skipped
// (RL7) host writes ready mode to the mode register before configuration
// (RL8) host writes active mode to the mode register after configuration
// (RL9) device starts active clocks per the profile after the full sequence
// (RL10) each transfer carries 8-bit address and 8-bit data; 8-bit register space
// (RL11) host keeps pll reference between 10 and 50 MHz
// (RL12) host keeps vco between 2.375 and 2.625 GHz
// (RL13) pll input from crystal, two clock inputs or differential, by field or pins
// (RL14) host groups outputs by ratios of integers 1 to 63
// (RL15) device has five integer and two fractional output dividers
// (RL16) host keeps integer dividers 8..255, fractional 10..255
// (RL17) feedback integer, numerator, denominator are 15-bit fields
// (RL18) host checks every acknowledge and aborts on a missing one; read_reg ignores its acknowledges
`timescale 1ns/10ps
`include "vcd_cfg.svh"
module volatile_config_download #(
    parameter logic [6:0]       BUS_ADDR           = `VCD_I2C_ADDR,
    parameter bit               NVM_PROFILE_LOADED = 1'b0,
    parameter int               GPI_W              = 4,
    parameter logic [GPI_W-1:0] GLOBAL_GPI_MASK    = '0,
    parameter bit               HAS_SEL_PINS       = 1'b0
) (
    input  wire logic                    i_core_clk,
    input  wire logic                    i_rst_n,
    input  wire logic                    i_scl,
    input  wire logic                    i_sda,
    output logic                         o_sda,
    output logic                         o_sda_oe_n,
    input  wire logic [GPI_W-1:0]        i_gpi,
    input  wire logic [1:0]              i_input_select_pins,
    output logic                         o_clocks_active,
    output logic                         o_ready_mode,
    output vcd_pkg::clock_plan_type      o_clock_plan,
    output logic [GPI_W-1:0]             o_gpi_function
);

    localparam int SW = 4 + GPI_W;

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisation

    logic [SW-1:0]    sync_bus;
    logic             scl_s;
    logic             sda_s;
    logic [GPI_W-1:0] gpi_s;
    logic [1:0]       sel_s;

    vcd_sync #(
        .W (SW)
    ) u_sync (
        .i_core_clk (i_core_clk),
        .i_rst_n    (i_rst_n),
        .i_async    ({i_input_select_pins, i_gpi, i_sda, i_scl}),
        .o_sync     (sync_bus)
    );

    // split the synchronised bank
    assign scl_s = sync_bus[0];
    assign sda_s = sync_bus[1];
    assign gpi_s = sync_bus[2 +: GPI_W];
    assign sel_s = sync_bus[2+GPI_W +: 2];

    ////////////////////////////////////////////////////////////////////////////
    // state

    vcd_pkg::i2c_state_type  state;
    vcd_pkg::i2c_state_type  next_state;
    logic                    scl_d;
    logic                    sda_d;
    logic [7:0]              shift;
    logic [7:0]              next_shift;
    logic [3:0]              bitcnt;
    logic [3:0]              next_bitcnt;
    logic [7:0]              ptr;
    logic [7:0]              next_ptr;
    logic                    rw;
    logic                    next_rw;
    logic                    nack;
    logic                    next_nack;
    logic                    next_sda_oe_n;
    logic [7:0]              mode;
    logic [7:0]              next_mode;
    logic                    armed;
    logic                    next_armed;
    logic                    next_clocks_active;
    logic                    next_ready_mode;
    vcd_pkg::clock_plan_type next_plan;
    logic [GPI_W-1:0]        next_gpi_function;
    logic                    wr_en;
    logic [7:0]              wr_addr;
    logic [7:0]              wr_data;
    logic [7:0]              mem [0:255];
    logic                    start_cond;
    logic                    stop_cond;
    logic                    scl_rise;
    logic                    scl_fall;

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // register read view, mode register kept apart from the array
    function automatic logic [7:0] read_byte(input logic [7:0] a);
        if (a == `VCD_MODE_ADDR) begin
            read_byte = mode;
        end else begin
            read_byte = mem[a];
        end
    endfunction

    // 15-bit field from a low and high byte
    function automatic logic [14:0] field15(input logic [7:0] lo, input logic [7:0] hi);
        field15 = {hi[6:0], lo};
    endfunction

    // bus conditions seen on the synchronised lines
    assign start_cond = scl_s & scl_d & sda_d & ~sda_s;
    assign stop_cond  = scl_s & scl_d & ~sda_d & sda_s;
    assign scl_rise   = scl_s & ~scl_d;
    assign scl_fall   = ~scl_s & scl_d;

    ////////////////////////////////////////////////////////////////////////////
    // next-state logic

    always_comb begin
        logic [7:0] rb;
        rb                 = 8'h00;
        next_state         = state;
        next_shift         = shift;
        next_bitcnt        = bitcnt;
        next_ptr           = ptr;
        next_rw            = rw;
        next_nack          = nack;
        next_sda_oe_n      = o_sda_oe_n;
        next_mode          = mode;
        next_armed         = armed;
        next_clocks_active = o_clocks_active;
        next_plan          = o_clock_plan;
        next_gpi_function  = gpi_s & GLOBAL_GPI_MASK; // RL2 RL3
        wr_en              = 1'b0;
        wr_addr            = ptr;
        wr_data            = shift;

        if (stop_cond) begin
            next_state    = vcd_pkg::ST_IDLE;
            next_sda_oe_n = 1'b1;
        end else if (start_cond) begin
            next_state    = vcd_pkg::ST_ADDR;
            next_bitcnt   = 4'h0;
            next_sda_oe_n = 1'b1;
        end else if (scl_rise) begin
            case (state)
                vcd_pkg::ST_ADDR, vcd_pkg::ST_PTR, vcd_pkg::ST_DATA: begin
                    next_shift  = {shift[6:0], sda_s};
                    next_bitcnt = bitcnt + 4'h1;
                end
                vcd_pkg::ST_READ_ACK: begin
                    next_nack = sda_s;
                end
                default: begin
                end
            endcase
        end else if (scl_fall) begin
            case (state)
                vcd_pkg::ST_ADDR: begin
                    if (bitcnt == `VCD_BITS_PER_BYTE) begin
                        if (shift[7:1] == BUS_ADDR) begin
                            next_rw       = shift[0];
                            next_sda_oe_n = 1'b0;
                            next_state    = vcd_pkg::ST_ADDR_ACK;
                        end else begin
                            next_state = vcd_pkg::ST_IDLE;
                        end
                    end
                end
                vcd_pkg::ST_ADDR_ACK, vcd_pkg::ST_READ_ACK: begin
                    if (state == vcd_pkg::ST_READ_ACK && nack) begin
                        next_sda_oe_n = 1'b1;
                        next_state    = vcd_pkg::ST_IDLE;
                    end else if (rw) begin
                        rb            = read_byte(ptr);
                        next_shift    = rb;
                        next_sda_oe_n = rb[7];
                        next_bitcnt   = 4'h1;
                        next_state    = vcd_pkg::ST_READ;
                    end else begin
                        next_sda_oe_n = 1'b1;
                        next_bitcnt   = 4'h0;
                        next_state    = vcd_pkg::ST_PTR;
                    end
                end
                vcd_pkg::ST_PTR: begin
                    if (bitcnt == `VCD_BITS_PER_BYTE) begin
                        next_ptr      = shift; // RL10
                        next_sda_oe_n = 1'b0;
                        next_state    = vcd_pkg::ST_PTR_ACK;
                    end
                end
                vcd_pkg::ST_PTR_ACK, vcd_pkg::ST_DATA_ACK: begin
                    next_sda_oe_n = 1'b1;
                    next_bitcnt   = 4'h0;
                    next_state    = vcd_pkg::ST_DATA;
                end
                vcd_pkg::ST_DATA: begin
                    if (bitcnt == `VCD_BITS_PER_BYTE) begin
                        next_sda_oe_n = 1'b0;
                        next_ptr      = ptr + 8'h01;
                        next_state    = vcd_pkg::ST_DATA_ACK;
                        if (ptr == `VCD_MODE_ADDR) begin
                            next_mode = shift;
                            if (shift == `VCD_MODE_READY) begin
                                next_armed         = 1'b1; // RL1
                                next_clocks_active = 1'b0; // RL1
                            end else if (shift == `VCD_MODE_ACTIVE && armed) begin
                                next_armed         = 1'b0;
                                next_clocks_active = 1'b1; // RL9
                                for (int i = 0; i < `VCD_INT_DIV_COUNT; i++) begin
                                    next_plan.int_div[i] = mem[`VCD_INT_DIV_BASE + 8'(i)]; // RL15
                                end
                                for (int j = 0; j < `VCD_FRAC_DIV_COUNT; j++) begin
                                    next_plan.frac_div[j] = mem[`VCD_FRAC_DIV_BASE + 8'(j)]; // RL15
                                end
                                next_plan.fb_integer     = field15(mem[`VCD_FB_INT_LO], mem[`VCD_FB_INT_HI]);
                                next_plan.fb_numerator   = field15(mem[`VCD_FB_NUM_LO], mem[`VCD_FB_NUM_HI]);
                                next_plan.fb_denominator = field15(mem[`VCD_FB_DEN_LO], mem[`VCD_FB_DEN_HI]);
                                next_plan.input_sel      = vcd_pkg::input_source_type'(
                                                           mem[`VCD_INPUT_MUX_ADDR][1:0]); // RL13
                            end
                        end else if (ptr < `VCD_GPI_BASE) begin
                            wr_en = 1'b1; // RL2
                        end
                    end
                end
                vcd_pkg::ST_READ: begin
                    if (bitcnt == `VCD_BITS_PER_BYTE) begin
                        next_sda_oe_n = 1'b1;
                        next_ptr      = ptr + 8'h01;
                        next_state    = vcd_pkg::ST_READ_ACK;
                    end else begin
                        next_shift    = {shift[6:0], 1'b1};
                        next_sda_oe_n = shift[6];
                        next_bitcnt   = bitcnt + 4'h1;
                    end
                end
                default: begin
                end
            endcase
        end

        // select pins, where fitted, override the field
        if (HAS_SEL_PINS) begin
            next_plan.input_sel = vcd_pkg::input_source_type'(sel_s); // RL13
        end
        next_ready_mode = (next_mode == `VCD_MODE_READY);
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            state           <= vcd_pkg::ST_IDLE;
            scl_d           <= 1'b1;
            sda_d           <= 1'b1;
            shift           <= 8'h00;
            bitcnt          <= 4'h0;
            ptr             <= 8'h00;
            rw              <= 1'b0;
            nack            <= 1'b0;
            o_sda           <= 1'b0;
            o_sda_oe_n      <= 1'b1;
            mode            <= NVM_PROFILE_LOADED ? `VCD_MODE_ACTIVE : `VCD_MODE_RESET;
            armed           <= 1'b0;
            o_clocks_active <= NVM_PROFILE_LOADED; // RL1
            o_ready_mode    <= 1'b0;
            o_clock_plan    <= '0;
            o_gpi_function  <= '0;
            for (int k = 0; k < 256; k++) begin
                mem[k] <= 8'h00;
            end
        end else begin
            state           <= next_state;
            scl_d           <= scl_s;
            sda_d           <= sda_s;
            shift           <= next_shift;
            bitcnt          <= next_bitcnt;
            ptr             <= next_ptr;
            rw              <= next_rw;
            nack            <= next_nack;
            o_sda           <= 1'b0; // open drain, only ever pulls low
            o_sda_oe_n      <= next_sda_oe_n;
            mode            <= next_mode;
            armed           <= next_armed;
            o_clocks_active <= next_clocks_active;
            o_ready_mode    <= next_ready_mode;
            o_clock_plan    <= next_plan;
            o_gpi_function  <= next_gpi_function;
            if (wr_en) begin
                mem[wr_addr] <= wr_data;
            end
        end
    end

endmodule

/* volatile_config_download_asserts.sv */
// Purpose: concurrent checks on the ports of the download block
// Assumes: one clock domain, synchronous active-low reset
// Notes:   bound from the testbench top file
`timescale 1ns/10ps
module volatile_config_download_asserts #(
    parameter int               GPI_W           = 4,
    parameter logic [GPI_W-1:0] GLOBAL_GPI_MASK = '0
) (
    input  wire logic                    i_core_clk,
    input  wire logic                    i_rst_n,
    input  wire logic                    i_scl,
    input  wire logic [GPI_W-1:0]        i_gpi,
    input  wire logic                    o_sda_oe_n,
    input  wire logic                    o_clocks_active,
    input  wire logic                    o_ready_mode,
    input  wire vcd_pkg::clock_plan_type o_clock_plan,
    input  wire logic [GPI_W-1:0]        o_gpi_function
);
    logic [2:0] up_cnt;
    logic [2:0] next_up_cnt;
    logic       seen_ready;
    logic       next_seen_ready;

    ////////////////////////////////////////////////////////////////////////
    // cycles since reset release, and ready mode seen since then
    always_comb begin
        next_up_cnt     = (up_cnt == 3'h7) ? up_cnt : up_cnt + 3'h1;
        next_seen_ready = seen_ready | o_ready_mode;
    end
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            up_cnt     <= 3'h0;
            seen_ready <= 1'b0;
        end else begin
            up_cnt     <= next_up_cnt;
            seen_ready <= next_seen_ready;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // properties
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);

    a_ready_no_clk: assert property (o_ready_mode |-> !o_clocks_active)
        else $error("clocks running in ready mode");
    a_blank_quiet: assert property (o_clocks_active |-> seen_ready)
        else $error("clocks started without ready mode");
    a_start_from_ready: assert property ($rose(o_clocks_active) |-> $past(o_ready_mode) && !o_ready_mode)
        else $error("clocks started outside the ready to active step");
    a_stop_by_ready: assert property ($fell(o_clocks_active) |-> o_ready_mode)
        else $error("clocks stopped without ready mode");
    a_plan_on_start: assert property ($changed(o_clock_plan) |-> $rose(o_clocks_active))
        else $error("clock plan changed outside activation");
    a_gpi_no_add: assert property ((o_gpi_function & ~GLOBAL_GPI_MASK) == '0)
        else $error("pin function outside the global set");
    a_gpi_follows: assert property ($stable(i_gpi)[*4] ##0 (up_cnt == 3'h7)
                                    |-> o_gpi_function == (i_gpi & GLOBAL_GPI_MASK))
        else $error("global pin function not following its pin");
    a_sda_scl_low: assert property ($changed(o_sda_oe_n) |-> !i_scl && !$past(i_scl))
        else $error("data line changed while bus clock high");
    a_ack_bounded: assert property ($fell(o_sda_oe_n) |-> ##[1:400] o_sda_oe_n)
        else $error("data line held low too long");

    cover property ($rose(o_clocks_active));
    cover property ($fell(o_sda_oe_n));
    cover property (o_gpi_function != '0);
endmodule

/* vcd_host_model.sv */
// Purpose: host bus master that downloads and reads back registers
// Assumes: bus clock half period of 10 core clocks, pull-up on data
// Notes:   tasks are called from the testbench through the instance
`timescale 1ns/10ps
module vcd_host_model (
    input  wire logic i_core_clk,
    input  wire logic i_sda,
    output logic      o_scl,
    output logic      o_sda_low
);
    initial begin
        o_scl     = 1'b1;
        o_sda_low = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // wait n core clocks, then step just past the edge
    task automatic tick(input int n);
        repeat (n) @(posedge i_core_clk);
        #1;
    endtask

    // start or repeated start: data falls while bus clock is high
    task automatic start();
        o_sda_low = 1'b0;
        tick(5);
        o_scl = 1'b1;
        tick(10);
        o_sda_low = 1'b1;
        tick(10);
        o_scl = 1'b0;
        tick(5);
    endtask

    // stop: data rises while bus clock is high, bus left idle
    task automatic stop();
        o_sda_low = 1'b1;
        tick(5);
        o_scl = 1'b1;
        tick(10);
        o_sda_low = 1'b0;
        tick(10);
    endtask

    // one byte out msb first, then the slave's acknowledge
    task automatic put_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            o_sda_low = ~b[i];
            tick(5);
            o_scl = 1'b1;
            tick(10);
            o_scl = 1'b0;
            tick(5);
        end
        o_sda_low = 1'b0;
        tick(5);
        o_scl = 1'b1;
        tick(5);
        ack = (i_sda === 1'b0);
        tick(5);
        o_scl = 1'b0;
        tick(5);
    endtask

    // one byte in msb first, then acknowledge unless last
    task automatic get_byte(input logic last, output logic [7:0] d);
        o_sda_low = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            tick(5);
            o_scl = 1'b1;
            tick(5);
            d[i] = i_sda;
            tick(5);
            o_scl = 1'b0;
            tick(5);
        end
        o_sda_low = ~last;
        tick(5);
        o_scl = 1'b1;
        tick(10);
        o_scl = 1'b0;
        tick(5);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // one register write; gives up at the first missing acknowledge
    task automatic write_reg(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] d, output logic ok);
        logic k0;
        logic k1;
        logic k2;
        k1 = 1'b0;
        k2 = 1'b0;
        start();
        put_byte({dev, 1'b0}, k0);
        if (k0) put_byte(a, k1);
        if (k1) put_byte(d, k2);
        stop();
        ok = k0 & k1 & k2;
    endtask

    // one register read through a repeated start
    task automatic read_reg(input logic [6:0] dev, input logic [7:0] a, output logic [7:0] d);
        logic k;
        start();
        put_byte({dev, 1'b0}, k);
        put_byte(a, k);
        start();
        put_byte({dev, 1'b1}, k);
        get_byte(1'b1, d);
        stop();
    endtask
endmodule

/* volatile_config_download_tb.sv */
// Purpose: self-checking bench for the volatile configuration download
// Assumes: blank profile with two global pin functions, no select pins
// Notes:   all register traffic goes through the host model
`timescale 1ns/10ps
`include "vcd_cfg.svh"
module volatile_config_download_tb;
    logic                    clk;
    logic                    i_rst_n;
    logic                    scl;
    logic                    host_low;
    logic                    sda_line;
    logic                    sda_out;
    logic                    sda_oe_n;
    logic [3:0]              gpi;
    logic [1:0]              sel_pins;
    logic                    clocks_active;
    logic                    ready_mode;
    vcd_pkg::clock_plan_type plan;
    vcd_pkg::clock_plan_type exp_plan;
    logic [3:0]              gpi_function;
    logic [7:0]              rd;
    logic                    ok;
    int                      error_cnt;
    int                      samples_checked;
    logic [15:0]             prof [$];

    // open-drain data wire with pull-up
    assign sda_line = ~(host_low | ~sda_oe_n);

    volatile_config_download #(
        .GLOBAL_GPI_MASK (4'h3)
    ) dut (
        .i_core_clk          (clk),
        .i_rst_n             (i_rst_n),
        .i_scl               (scl),
        .i_sda               (sda_line),
        .o_sda               (sda_out),
        .o_sda_oe_n          (sda_oe_n),
        .i_gpi               (gpi),
        .i_input_select_pins (sel_pins),
        .o_clocks_active     (clocks_active),
        .o_ready_mode        (ready_mode),
        .o_clock_plan        (plan),
        .o_gpi_function      (gpi_function)
    );

    vcd_host_model host (
        .i_core_clk (clk),
        .i_sda      (sda_line),
        .o_scl      (scl),
        .o_sda_low  (host_low)
    );

    initial clk = 1'b0;
    always #5 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////
    // compare, count and report
    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic results();
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host.write_reg(`VCD_I2C_ADDR, a, d, ok);
        check(128'(ok), 128'h1);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        error_cnt       = 0;
        samples_checked = 0;
        i_rst_n         = 1'b0;
        gpi             = 4'hf;
        sel_pins        = 2'h3;
        // single profile in range: dividers 8..255 and 10..255, 15-bit feedback fields
        prof = '{16'h0601, 16'h2008, 16'h2109, 16'h2264, 16'h23fe, 16'h24ff, 16'h280a, 16'h29ff, 16'h2c02,
                 16'h3000, 16'h3132, 16'h3234, 16'h3392, 16'h34ff, 16'h35ff, 16'hf0ff, 16'h0602};
        exp_plan.int_div        = {8'hff, 8'hfe, 8'h64, 8'h09, 8'h08};
        exp_plan.frac_div       = {8'hff, 8'h0a};
        exp_plan.fb_integer     = 15'h3200;
        exp_plan.fb_numerator   = 15'h1234;
        exp_plan.fb_denominator = 15'h7fff;
        exp_plan.input_sel      = vcd_pkg::SRC_CLKIN2;
        repeat (5) @(posedge clk);
        #1;
        i_rst_n = 1'b1;
        repeat (4) @(posedge clk);
        #1;
        // blank after power-up: no clocks, only global pin functions
        check(128'({sda_out, clocks_active, ready_mode, plan}), 128'h0);
        check(128'(gpi_function), 128'h3);
        // foreign slave address ignored; active without ready refused
        host.write_reg(`VCD_I2C_ADDR ^ 7'h01, `VCD_MODE_ADDR, `VCD_MODE_READY, ok);
        check(128'({ok, ready_mode}), 128'h0);
        wr(`VCD_MODE_ADDR, `VCD_MODE_ACTIVE);
        check(128'(clocks_active), 128'h0);
        // download: ready first, every pair in order, active last
        foreach (prof[i]) begin
            wr(prof[i][15:8], prof[i][7:0]);
            if (!ok) break;
            if (i == 0) check(128'({ready_mode, clocks_active}), 128'h2);
        end
        check(128'({clocks_active, ready_mode}), 128'h2);
        check(128'(plan), 128'(exp_plan));
        host.read_reg(`VCD_I2C_ADDR, 8'h20, rd);
        check(128'(rd), 128'h8);
        host.read_reg(`VCD_I2C_ADDR, 8'hf0, rd);
        check(128'(rd), 128'h0);
        // every pll input source through the mux field, pins disagreeing
        for (int s = 0; s < 4; s++) begin
            sel_pins = 2'(3 - s);
            wr(`VCD_MODE_ADDR, `VCD_MODE_READY);
            wr(`VCD_INPUT_MUX_ADDR, 8'(s));
            wr(`VCD_MODE_ADDR, `VCD_MODE_ACTIVE);
            check(128'(plan.input_sel), 128'(s));
        end
        // global pins still follow their levels after the download
        gpi = 4'h5;
        repeat (4) @(posedge clk);
        #1;
        check(128'(gpi_function), 128'h1);
        results();
    end

    // watchdog well beyond the expected run time
    initial begin
        #400_000;
        error_cnt++;
        results();
    end
endmodule

bind volatile_config_download volatile_config_download_asserts #(
    .GPI_W           (GPI_W),
    .GLOBAL_GPI_MASK (GLOBAL_GPI_MASK)
) chk (
    .i_core_clk      (i_core_clk),
    .i_rst_n         (i_rst_n),
    .i_scl           (i_scl),
    .i_gpi           (i_gpi),
    .o_sda_oe_n      (o_sda_oe_n),
    .o_clocks_active (o_clocks_active),
    .o_ready_mode    (o_ready_mode),
    .o_clock_plan    (o_clock_plan),
    .o_gpi_function  (o_gpi_function)
);
